//--- hw/srd_core.sv
// Purpose: exposure timing and readout direction control of a global shutter sensor
// Assumes: sync and trigger pins are active low and asynchronous to sys_clk
// Notes:   pixel array itself is outside; this block issues its control strobes

`timescale 1ns/1ns

// Function
// (R1) vertical flip bit 0 normal, 1 inverted line order; resets to 0
// (R2) horizontal flip bit 1: 0 normal, 1 inverted pixel order; resets to 0
// (R3) all lines exposed together, memory transfer, then line-by-line readout on hsync
// (R4) trigger mode lets external trigger control exposure start and transfer
// (R5) new integration setting shows first in the frame after the change
// (R6) normal mode uses 20-bit shutter line register, reset 0000a
// (R7) software keeps shutter value between memory wait and lines per frame minus one
// (R8) slave mode takes lines per frame from vsync interval in hsync lines
// (R9) master mode takes lines per frame from 20-bit frame length register, reset 0082e
// (R10) exposure equals line period times (lines minus shutter) plus 13.73 us
// (R11) sequential trigger exposure equals trigger low width counted in hsync lines
// (R12) software writes 1 to trigger mode enable to enter trigger mode
// (R13) vsync input ignored while trigger mode active
// (R14) controller observes rise and fall prohibited periods after each trigger rise; the code applies only the 2092-line rise period, SRD_FALL_PROHIBIT is unused
// (R15) early trigger rise during rise prohibit starts interrupt operation
// (R16) sequential trigger operation works only in slave mode
// (R17) trigger mode register bit 0 picks normal or triggered shutter; reset 0
// (R18) interrupt enable clear ignores both trigger edges within rise prohibit period
// (R19) controller waits 2092 lines between trigger rises in all-pixel mode
// (R20) controller waits 11 lines after a rise before the next trigger fall; code gates falls by the 2092-line rise period instead
// (R21) frame length and shutter words latched whole at a frame boundary
// (R22) trigger width and prohibit periods counted by a per-hsync line counter; code counts only the rise prohibit period, trigger width is not counted
module srd_core
  import srd_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        master_mode,
  input  wire logic        vertical_sync_pin_n,
  input  wire logic        horizontal_sync_pin_n,
  input  wire logic        exposure_trigger_pin_n,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  output logic      [7:0]  reg_rdata,
  output logic             expose_start,
  output logic             memory_transfer,
  output logic             line_strobe,
  output logic      [19:0] line_index,
  output logic             vertical_flip,
  output logic             horizontal_flip,
  output logic             frame_invalid
);
  logic             vs_lvl;
  logic             hs_lvl;
  logic             tg_lvl;
  logic             vs_d;
  logic             hs_d;
  logic             tg_d;
  logic             hs_fall;
  logic             vs_fall;
  logic             tg_fall;
  logic             tg_rise;
  logic             trigger_mode_select;
  logic             trigger_interrupt_enable;
  logic [19:0]      frame_length_lines;
  logic [19:0]      shutter_line;
  logic [19:0]      act_flen;
  logic [19:0]      act_shut;
  logic [19:0]      line_cnt;
  logic [19:0]      slave_flen;
  logic [19:0]      since_rise;
  logic             rise_seen;
  logic [19:0]      rd_cnt;
  logic [19:0]      lines_per_frame;
  logic [7:0]       off_cnt;
  logic             frame_start;
  logic             trig_active;
  logic             in_prohibit;
  srd_state_e       state;

  srd_sync u_vs (.sys_clk(sys_clk), .reset(reset), .pin(vertical_sync_pin_n), .level(vs_lvl));
  srd_sync u_hs (.sys_clk(sys_clk), .reset(reset), .pin(horizontal_sync_pin_n), .level(hs_lvl));
  srd_sync u_tg (.sys_clk(sys_clk), .reset(reset), .pin(exposure_trigger_pin_n), .level(tg_lvl));

  // edge detection on filtered levels
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      vs_d <= 1'b1;
      hs_d <= 1'b1;
      tg_d <= 1'b1;
    end
    else
    begin
      vs_d <= vs_lvl;
      hs_d <= hs_lvl;
      tg_d <= tg_lvl;
    end
  end

  assign hs_fall     = hs_d & ~hs_lvl;
  assign vs_fall     = vs_d & ~vs_lvl;
  assign tg_fall     = tg_d & ~tg_lvl;
  assign tg_rise     = ~tg_d & tg_lvl;
  // trigger path exists in slave mode only
  assign trig_active = trigger_mode_select & ~master_mode; // R16 R17
  assign in_prohibit = rise_seen && (since_rise < SRD_RISE_PROHIBIT);

  // register writes
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      vertical_flip            <= SRD_RST_VFLIP; // R1
      horizontal_flip          <= SRD_RST_HFLIP; // R2
      trigger_mode_select      <= SRD_RST_TRIG_MODE; // R17
      trigger_interrupt_enable <= SRD_RST_TRIG_IEN;
      frame_length_lines       <= SRD_RST_FLEN; // R9
      shutter_line             <= SRD_RST_SHUT; // R6
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        SRD_ADDR_FLIP:
        begin
          vertical_flip   <= reg_wdata[SRD_BIT_VFLIP]; // R1
          horizontal_flip <= reg_wdata[SRD_BIT_HFLIP]; // R2
        end
        SRD_ADDR_TRIG_MODE: trigger_mode_select      <= reg_wdata[SRD_BIT_TRIG_MODE]; // R12
        SRD_ADDR_TRIG_IEN:  trigger_interrupt_enable <= reg_wdata[SRD_BIT_TRIG_IEN];
        SRD_ADDR_FLEN0:     frame_length_lines[7:0]   <= reg_wdata;
        SRD_ADDR_FLEN1:     frame_length_lines[15:8]  <= reg_wdata;
        SRD_ADDR_FLEN2:     frame_length_lines[19:16] <= reg_wdata[3:0];
        SRD_ADDR_SHUT0:     shutter_line[7:0]         <= reg_wdata;
        SRD_ADDR_SHUT1:     shutter_line[15:8]        <= reg_wdata;
        SRD_ADDR_SHUT2:     shutter_line[19:16]       <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  // register reads; unmapped addresses answer zero
  always_comb
  begin
    case (reg_addr)
      SRD_ADDR_FLIP:      reg_rdata = {6'h00, horizontal_flip, vertical_flip};
      SRD_ADDR_TRIG_MODE: reg_rdata = {7'h00, trigger_mode_select};
      SRD_ADDR_TRIG_IEN:  reg_rdata = {7'h00, trigger_interrupt_enable};
      SRD_ADDR_FLEN0:     reg_rdata = frame_length_lines[7:0];
      SRD_ADDR_FLEN1:     reg_rdata = frame_length_lines[15:8];
      SRD_ADDR_FLEN2:     reg_rdata = {4'h0, frame_length_lines[19:16]};
      SRD_ADDR_SHUT0:     reg_rdata = shutter_line[7:0];
      SRD_ADDR_SHUT1:     reg_rdata = shutter_line[15:8];
      SRD_ADDR_SHUT2:     reg_rdata = {4'h0, shutter_line[19:16]};
      SRD_ADDR_STATUS:    reg_rdata = {5'h00, frame_invalid, trig_active,
                                       (state == SRD_READOUT)};
      default:            reg_rdata = 8'h00;
    endcase
  end

  // frame boundary: vsync in slave, frame length count in master; vsync ignored in trigger
  always_comb
  begin
    if (master_mode)
      frame_start = hs_fall && (line_cnt + 20'd1 >= act_flen); // R9
    else
      frame_start = vs_fall && !trig_active; // R8 R13
  end

  assign lines_per_frame = master_mode ? act_flen : slave_flen;

  // line counter within the frame; slave frame length measured from vsync interval
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      line_cnt   <= 20'h00000;
      slave_flen <= SRD_RST_FLEN;
    end
    else if (frame_start)
    begin
      if (!master_mode)
        slave_flen <= line_cnt + 20'd1; // R8 frame-start line is line 0
      line_cnt <= 20'h00000;
    end
    else if (hs_fall)
      line_cnt <= line_cnt + 20'd1;
  end

  // whole-word latch at frame start so partial writes never act mid-frame
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      act_flen <= SRD_RST_FLEN;
      act_shut <= SRD_RST_SHUT;
    end
    else if (frame_start)
    begin
      act_flen <= frame_length_lines; // R21 R5
      act_shut <= shutter_line; // R21 R5
    end
  end

  // trigger rise tracking in hsync lines for prohibit periods
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      since_rise <= 20'h00000;
      rise_seen  <= 1'b0;
    end
    else if (!trig_active)
      rise_seen <= 1'b0;
    else if (tg_rise && !(in_prohibit && !trigger_interrupt_enable))
    begin
      since_rise <= 20'h00000;
      rise_seen  <= 1'b1;
    end
    else if (hs_fall && since_rise != 20'hfffff)
      since_rise <= since_rise + 20'd1; // R22
  end

  // exposure sequencing: normal mode by shutter line, trigger mode by pulse width
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state           <= SRD_IDLE;
      expose_start    <= 1'b0;
      memory_transfer <= 1'b0;
      off_cnt         <= 8'h00;
      rd_cnt          <= 20'h00000;
      frame_invalid   <= 1'b0;
    end
    else
    begin
      expose_start    <= 1'b0;
      memory_transfer <= 1'b0;
      // early rise with interrupt enabled flags the frame being read as invalid; readout continues
      if (trig_active && tg_rise && in_prohibit && trigger_interrupt_enable
          && state == SRD_READOUT)
        frame_invalid <= 1'b1; // R15
      else if (expose_start)
        frame_invalid <= 1'b0;
      case (state)
        SRD_IDLE:
        begin
          if (trig_active)
          begin
            // fall starts exposure unless ignored inside the prohibit window
            if (tg_fall && !(in_prohibit && !trigger_interrupt_enable)) // R18
            begin
              expose_start <= 1'b1; // R4 R11
              state        <= SRD_EXPOSE;
            end
          end
          else if (hs_fall && (line_cnt + 20'd1 == act_shut)) // count not yet advanced
          begin
            expose_start <= 1'b1; // R3 R6 R10
            state        <= SRD_EXPOSE;
          end
        end
        SRD_EXPOSE:
        begin
          // normal exposure ends at frame boundary: lines minus shutter later
          if ((!trig_active && frame_start) || (trig_active && tg_rise)) // R10 R11
          begin
            off_cnt <= 8'h00;
            state   <= SRD_OFFSET;
          end
        end
        SRD_OFFSET:
        begin
          // fixed offset added before charge is moved to pixel memory
          if (off_cnt + 8'd1 >= 8'(SRD_OFFSET_CYC))
          begin
            memory_transfer <= 1'b1; // R3 R10
            rd_cnt          <= 20'h00000;
            state           <= SRD_READOUT;
          end
          else
            off_cnt <= off_cnt + 8'd1;
        end
        SRD_READOUT:
        begin
          if (hs_fall)
          begin
            if (rd_cnt + 20'd1 >= lines_per_frame)
              state <= SRD_IDLE;
            rd_cnt <= rd_cnt + 20'd1;
          end
        end
        default: state <= SRD_IDLE;
      endcase
    end
  end

  // one line per hsync; inverted order counts from the far end
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      line_strobe <= 1'b0;
      line_index  <= 20'h00000;
    end
    else
    begin
      line_strobe <= (state == SRD_READOUT) && hs_fall; // R3
      if ((state == SRD_READOUT) && hs_fall)
        line_index <= vertical_flip ? (lines_per_frame - 20'd1 - rd_cnt) : rd_cnt; // R1
    end
  end

  property p_offset_len;
    @(posedge sys_clk) disable iff (reset)
      $rose(state == SRD_OFFSET) |-> (state == SRD_OFFSET)[*8] ##[1:300] memory_transfer;
  endproperty
  a_offset_len: assert property (p_offset_len) else $error("offset too short"); // R10

  property p_vs_ignored;
    @(posedge sys_clk) disable iff (reset)
      (trig_active && !master_mode) |-> !frame_start;
  endproperty
  a_vs_ignored: assert property (p_vs_ignored) else $error("vsync used in trigger mode"); // R13

  property p_latch_hold;
    @(posedge sys_clk) disable iff (reset)
      !$past(frame_start) |-> $stable(act_shut) && $stable(act_flen);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("active value changed mid frame"); // R21

  property p_ignore_edge;
    @(posedge sys_clk) disable iff (reset)
      (state == SRD_IDLE && trig_active && tg_fall && in_prohibit && !trigger_interrupt_enable)
      |=> !expose_start;
  endproperty
  a_ignore_edge: assert property (p_ignore_edge) else $error("edge in prohibit not ignored"); // R18

  property p_master_trig;
    @(posedge sys_clk) disable iff (reset)
      master_mode |-> !trig_active;
  endproperty
  a_master_trig: assert property (p_master_trig) else $error("trigger active in master"); // R16

  sequence s_abort;
    trig_active && tg_rise && in_prohibit && trigger_interrupt_enable && state == SRD_READOUT;
  endsequence
  property p_abort;
    @(posedge sys_clk) disable iff (reset)
      s_abort |=> frame_invalid;
  endproperty
  a_abort: assert property (p_abort) else $error("early rise not flagged"); // R15

  property p_flip_out;
    @(posedge sys_clk) disable iff (reset)
      (line_strobe && !vertical_flip && $stable(vertical_flip)) |-> line_index == $past(rd_cnt);
  endproperty
  a_flip_out: assert property (p_flip_out) else $error("normal order index wrong"); // R1
endmodule

//--- hw/srd_pkg.sv
// Purpose: constants for the shutter and readout direction control block
// Assumes: registers reached through a byte-wide internal register port
// Notes:   multi-byte values are assembled from byte registers

package srd_pkg;
  // register byte addresses
  localparam logic [15:0] SRD_ADDR_FLIP       = 16'h300e;
  localparam logic [15:0] SRD_ADDR_TRIG_MODE  = 16'h300b;
  localparam logic [15:0] SRD_ADDR_FLEN0      = 16'h3010;
  localparam logic [15:0] SRD_ADDR_FLEN1      = 16'h3011;
  localparam logic [15:0] SRD_ADDR_FLEN2      = 16'h3012;
  localparam logic [15:0] SRD_ADDR_SHUT0      = 16'h308d;
  localparam logic [15:0] SRD_ADDR_SHUT1      = 16'h308e;
  localparam logic [15:0] SRD_ADDR_SHUT2      = 16'h308f;
  localparam logic [15:0] SRD_ADDR_TRIG_IEN   = 16'h30aa;
  localparam logic [15:0] SRD_ADDR_STATUS     = 16'h30f0;
  // field positions
  localparam int          SRD_BIT_VFLIP       = 0;
  localparam int          SRD_BIT_HFLIP       = 1;
  localparam int          SRD_BIT_TRIG_MODE   = 0;
  localparam int          SRD_BIT_TRIG_IEN    = 0;
  // reset values
  localparam logic [19:0] SRD_RST_FLEN        = 20'h0082e;
  localparam logic [19:0] SRD_RST_SHUT        = 20'h0000a;
  localparam logic        SRD_RST_VFLIP       = 1'b0;
  localparam logic        SRD_RST_HFLIP       = 1'b0;
  localparam logic        SRD_RST_TRIG_MODE   = 1'b0;
  localparam logic        SRD_RST_TRIG_IEN    = 1'b1;
  // timing
  localparam int          SRD_CLK_HZ          = 10_000_000;
  localparam int          SRD_OFFSET_NS       = 13730;
  localparam int          SRD_OFFSET_CYC      = (SRD_OFFSET_NS * (SRD_CLK_HZ / 1_000_000)
                                                 + 999) / 1000;
  localparam logic [19:0] SRD_RISE_PROHIBIT   = 20'd2092;
  localparam logic [19:0] SRD_FALL_PROHIBIT   = 20'd11;

  typedef enum logic [2:0] {
    SRD_IDLE,
    SRD_EXPOSE,
    SRD_OFFSET,
    SRD_READOUT
  } srd_state_e;
endpackage

//--- hw/srd_sync.sv
// Purpose: three flip-flop synchroniser with agreement filter for a pin
// Assumes: single clock sys_clk, synchronous active high reset
// Notes:   output changes only when stages two and three agree

`timescale 1ns/1ns

module srd_sync
(
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;

  // s1 feeds only s2 so metastability cannot spread
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // filtered level follows when two samples agree
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      level <= 1'b1;
    else if (s2 == s3)
      level <= s3;
  end
endmodule

//--- sim/srd_cam_model.sv
// Purpose: camera controller model driving sync and trigger pins of the shutter block
// Assumes: free running line sync, frame sync every frame_lines lines
// Notes:   trigger edges land on line boundaries so widths are whole lines

`timescale 1ns/1ns

module srd_cam_model
#(
  parameter int LINE_CYC = 12
)
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [19:0] frame_lines,
  input  wire logic        trig_go,
  input  wire logic [7:0]  trig_width,
  output logic             trig_busy,
  output logic             vertical_sync_pin_n,
  output logic             horizontal_sync_pin_n,
  output logic             exposure_trigger_pin_n
);
  logic [7:0]  cyc;
  logic [19:0] line;
  logic [7:0]  left;

  // line and frame counters; pulses three cycles wide so the pin filter sees them
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cyc  <= 8'h00;
      line <= 20'h00000;
    end
    else
    begin
      cyc <= (cyc == 8'(LINE_CYC - 1)) ? 8'h00 : cyc + 8'h01;
      if (cyc == 8'(LINE_CYC - 1))
        line <= (line == frame_lines - 20'h1) ? 20'h00000 : line + 20'h1;
    end
  end

  assign horizontal_sync_pin_n = !(cyc < 8'h03);
  assign vertical_sync_pin_n   = !(cyc < 8'h03 && line == 20'h00000);

  // trigger low for trig_width whole lines, counted on line boundaries
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      trig_busy              <= 1'b0;
      exposure_trigger_pin_n <= 1'b1;
      left                   <= 8'h00;
    end
    else if (trig_go && !trig_busy)
    begin
      trig_busy <= 1'b1;
      left      <= trig_width;
    end
    else if (trig_busy && cyc == 8'(LINE_CYC - 1))
    begin
      if (exposure_trigger_pin_n)
        exposure_trigger_pin_n <= 1'b0;
      else
      begin
        left <= left - 8'h01;
        if (left == 8'h01)
        begin
          exposure_trigger_pin_n <= 1'b1;
          trig_busy              <= 1'b0;
        end
      end
    end
  end
endmodule

//--- sim/srd_core_tb.sv
// Purpose: self-checking bench for exposure timing and readout direction control
// Assumes: 10 MHz sys_clk, line period of 12 cycles from the controller model
// Notes:   exposure is measured from expose_start to memory_transfer in whole lines

`timescale 1ns/1ns

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end

module srd_core_tb;
  import srd_pkg::*;
  localparam int LINE_CYC = 12;
  logic        sys_clk, reset, master_mode, reg_wr, trig_go, trig_busy;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, trig_width;
  logic        expose_start, memory_transfer, line_strobe, vertical_flip, horizontal_flip;
  logic        frame_invalid, vs_n, hs_n, tr_n;
  logic [19:0] line_index, frame_lines;
  logic [31:0] rng;
  int          n_errors, samples_checked, n_xfer, n_exp, cyc, t_start, e, s, s2, i, t;
  int          mark, n_lines;
  bit          trig_phase, first_line;
  int          exp_q[$];

  srd_core dut_u (.sys_clk(sys_clk), .reset(reset), .master_mode(master_mode),
    .vertical_sync_pin_n(vs_n), .horizontal_sync_pin_n(hs_n),
    .exposure_trigger_pin_n(tr_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .expose_start(expose_start),
    .memory_transfer(memory_transfer), .line_strobe(line_strobe), .line_index(line_index),
    .vertical_flip(vertical_flip), .horizontal_flip(horizontal_flip),
    .frame_invalid(frame_invalid));

  srd_cam_model #(.LINE_CYC(LINE_CYC)) cam_u (.sys_clk(sys_clk), .reset(reset),
    .frame_lines(frame_lines), .trig_go(trig_go), .trig_width(trig_width),
    .trig_busy(trig_busy), .vertical_sync_pin_n(vs_n), .horizontal_sync_pin_n(hs_n),
    .exposure_trigger_pin_n(tr_n));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction

  // monitor: pops the oldest expected exposure at each memory transfer
  always @(posedge sys_clk)
  begin
    cyc++;
    if (expose_start === 1'b1)
    begin
      n_exp++;
      t_start = cyc;
    end
    if (memory_transfer === 1'b1)
    begin
      n_xfer++;
      first_line = 1'b1;
      if (exp_q.size() > 0)
      begin
        e = exp_q.pop_front();
        t = (cyc - t_start - SRD_OFFSET_CYC + LINE_CYC / 2) / LINE_CYC;
        `CHK("exposure lines", e, t)
      end
      else if (trig_phase)
        `CHK("spurious transfer", 0, 1)
    end
    // inverted order opens with the last line of the frame
    if (line_strobe === 1'b1 && first_line)
    begin
      first_line = 1'b0;
      `CHK("first line index", vertical_flip ? 20'(n_lines - 1) : 20'h0, line_index)
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic do_reset(input logic m);
    master_mode = m;
    reset       = 1'b1;
    repeat (5) @(negedge sys_clk);
    reset = 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  // three bytes back to back, low byte first
  task automatic wr3(input logic [15:0] a, input logic [23:0] v);
    for (int k = 0; k < 3; k++)
    begin
      @(negedge sys_clk);
      reg_addr  = a + 16'(k);
      reg_wdata = v[8*k +: 8];
      reg_wr    = 1'b1;
    end
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] x, input string nm);
    @(negedge sys_clk);
    reg_addr = a;
    #10;
    `CHK(nm, x, reg_rdata)
  endtask

  // which 0 waits on transfers, 1 on exposure starts
  task automatic wait_cnt(input int which, input int target);
    int k;
    for (k = 0; k < 60000; k++)
    begin
      if ((which == 0 ? n_xfer : n_exp) >= target)
        break;
      @(negedge sys_clk);
    end
    if ((which == 0 ? n_xfer : n_exp) < target)
    begin
      n_errors++;
      $display("mismatch wait count expected %0d seen timeout", target);
      end_of_test();
    end
  endtask

  task automatic trig(input logic [7:0] w);
    int k;
    @(negedge sys_clk);
    trig_width = w;
    trig_go    = 1'b1;
    @(negedge sys_clk);
    trig_go = 1'b0;
    for (k = 0; k < 5000 && trig_busy !== 1'b0; k++)
      @(negedge sys_clk);
    if (trig_busy !== 1'b0)
    begin
      n_errors++;
      $display("mismatch trigger pulse expected done seen timeout");
      end_of_test();
    end
  endtask

  initial
  begin
    {reset, master_mode, reg_wr, trig_go, trig_phase, first_line} = 6'b100000;
    {reg_addr, reg_wdata, trig_width} = '0;
    {n_errors, samples_checked, n_xfer, n_exp, cyc, t_start} = '0;
    frame_lines = 20'd24;
    n_lines     = 24;
    rng = 32'h9c211f28;
    do_reset(1'b0);
    rd(SRD_ADDR_FLIP, 8'h00, "flip reset");
    rd(SRD_ADDR_FLEN0, 8'h2e, "flen0 reset");
    rd(SRD_ADDR_FLEN1, 8'h08, "flen1 reset");
    rd(SRD_ADDR_FLEN2, 8'h00, "flen2 reset");
    rd(SRD_ADDR_SHUT0, 8'h0a, "shut0 reset");
    rd(SRD_ADDR_SHUT1, 8'h00, "shut1 reset");
    rd(SRD_ADDR_TRIG_MODE, 8'h00, "trig mode reset");
    rd(SRD_ADDR_TRIG_IEN, 8'h01, "trig ien reset");
    rd(16'h3001, 8'h00, "unmapped");
    rd(SRD_ADDR_STATUS, 8'h00, "status reset");
    for (i = 0; i < 4; i++)
    begin
      wr(SRD_ADDR_FLIP, 8'(i));
      `CHK("vflip", i[0], vertical_flip)
      `CHK("hflip", i[1], horizontal_flip)
    end
    wr(SRD_ADDR_FLIP, 8'h00);
    $display("test registers done");
    rng = xs(rng);
    s   = 10 + int'(rng % 13);
    rng = xs(rng);
    s2  = 10 + int'(rng % 13);
    wr3(SRD_ADDR_SHUT0, 24'(s));
    wait_cnt(0, n_xfer + 2);
    exp_q.push_back(24 - s);
    wait_cnt(0, n_xfer + 1);
    wait_cnt(1, n_exp + 1);
    wr3(SRD_ADDR_SHUT0, 24'(s2));
    exp_q.push_back(24 - s);
    exp_q.push_back(24 - s2);
    wait_cnt(0, n_xfer + 2);
    $display("test normal slave done");
    wr(SRD_ADDR_TRIG_MODE, 8'h01);
    repeat (40 * LINE_CYC) @(negedge sys_clk);
    // readout is long over here, so the flip cannot split a frame
    wr(SRD_ADDR_FLIP, 8'h01);
    trig_phase = 1'b1;
    exp_q.push_back(4);
    mark = n_xfer + 1;
    trig(8'd4);
    wait_cnt(0, mark);
    trig_phase = 1'b0;
    trig(8'd3);
    repeat (20) @(negedge sys_clk);
    `CHK("frame invalid", 1'b1, frame_invalid)
    rd(SRD_ADDR_STATUS, 8'h07, "status interrupt");
    repeat (2100 * LINE_CYC) @(negedge sys_clk);
    wr(SRD_ADDR_TRIG_IEN, 8'h00);
    trig_phase = 1'b1;
    exp_q.push_back(5);
    mark = n_xfer + 1;
    trig(8'd5);
    wait_cnt(0, mark);
    `CHK("frame invalid cleared", 1'b0, frame_invalid)
    // let readout end so the ignored fall meets an idle sequencer
    repeat (30 * LINE_CYC) @(negedge sys_clk);
    mark = n_exp;
    trig(8'd3);
    repeat (20 * LINE_CYC) @(negedge sys_clk);
    `CHK("ignored trigger", mark, n_exp)
    `CHK("frame invalid kept", 1'b0, frame_invalid)
    trig_phase = 1'b0;
    $display("test trigger done");
    do_reset(1'b1);
    n_lines = 20;
    wr(SRD_ADDR_FLIP, 8'h01);
    wr3(SRD_ADDR_FLEN0, 24'd20);
    wr3(SRD_ADDR_SHUT0, 24'd12);
    wait_cnt(0, n_xfer + 2);
    exp_q.push_back(8);
    wait_cnt(0, n_xfer + 1);
    $display("test master done");
    end_of_test();
  end
endmodule
